// >>> src/nsc_nmi_ctrl.sv
// NMI status and system control ports: latched error sources, global mask,
// speaker and counter 2 gating, CMOS index, and pass-through of the index port.
// Assumes counter 2 output and refresh pulse come from logic on i_mclk,
// while the error pins are asynchronous.
//
// Behaviour
// - A system error pulse on the error pin sets the system error flag in bit 7.
// - Bit 2 written 1 clears and holds off the system error flag, written 0 enables it.
// - An asserted channel check pin sets the channel check flag in bit 6.
// - Bit 3 written 1 clears and holds off the channel check flag, written 0 enables it.
// - Bit 5 reads the live counter 2 output level.
// - Bit 4 flips after every completed refresh cycle.
// - Bit 1 gates the speaker: low when clear, counter 2 output when set.
// - Bit 0 enables counter 2 counting.
// - Bit 7 of the index port set blocks NMI delivery, clear allows it.
// - Index port accesses go to the peripheral bus, reads without chip select or strobe.
// - The low six bits of the index port hold the CMOS index; bit 6 is reserved.
`timescale 1ns/1ps
module nsc_nmi_ctrl (
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire nsc_pkg::nsc_io_req_type i_io_req,
    input wire logic i_system_error_low,
    input wire logic i_channel_check_low,
    input wire logic i_counter2_out,
    input wire logic i_refresh_done,
    output logic [7:0] o_io_rdata,
    output logic o_io_rdata_valid,
    output nsc_pkg::nsc_isa_cycle_type o_isa_cycle,
    output logic o_counter2_gate,
    output logic o_speaker_output,
    output logic o_nmi,
    output logic [5:0] o_cmos_index
);
    // ==========================================================
    // Reset release
    logic rst_meta_n;
    logic rst_n;

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta_n <= 1'h0;
            rst_n <= 1'h0;
        end else begin
            rst_meta_n <= 1'h1;
            rst_n <= rst_meta_n;
        end
    end

    // ==========================================================
    // Error pins
    logic [1:0] pin_level;

    nsc_pin_sync #(
        .WIDTH(2),
        .IDLE(2'h3)
    ) u_pin_sync (
        .i_mclk(i_mclk),
        .i_rst_n(rst_n),
        .i_pin({i_system_error_low, i_channel_check_low}),
        .o_level(pin_level)
    );

    logic system_error_seen;
    logic channel_check_seen;
    assign system_error_seen = !pin_level[1];
    assign channel_check_seen = !pin_level[0];

    // ==========================================================
    // Decode
    function automatic logic hit(input nsc_pkg::nsc_io_req_type req,
                                 input logic [15:0] port);
        return req.addr == port;
    endfunction

    logic wr_status;
    logic rd_status;
    logic wr_index;
    logic rd_index;
    assign wr_status = i_io_req.wr && hit(i_io_req, nsc_pkg::PORT_STATUS_CTRL);
    assign rd_status = i_io_req.rd && hit(i_io_req, nsc_pkg::PORT_CMOS_INDEX) == 1'h0
                       && hit(i_io_req, nsc_pkg::PORT_STATUS_CTRL);
    assign wr_index = i_io_req.wr && hit(i_io_req, nsc_pkg::PORT_CMOS_INDEX);
    assign rd_index = i_io_req.rd && hit(i_io_req, nsc_pkg::PORT_CMOS_INDEX);

    // ==========================================================
    // Control and status state
    nsc_pkg::nsc_ctrl_type ctrl;
    nsc_pkg::nsc_ctrl_type next_ctrl;
    logic system_error_flag;
    logic next_system_error_flag;
    logic channel_check_flag;
    logic next_channel_check_flag;
    logic refresh_toggle;
    logic next_refresh_toggle;
    logic global_nmi_mask;
    logic next_global_nmi_mask;
    logic [5:0] cmos_index;
    logic [5:0] next_cmos_index;

    always_comb begin
        next_ctrl = ctrl;
        next_global_nmi_mask = global_nmi_mask;
        next_cmos_index = cmos_index;
        // Upper bits of the write are not controls
        if (wr_status) begin
            next_ctrl.channel_check_disable = i_io_req.wdata[nsc_pkg::BIT_CHK_DIS];
            next_ctrl.system_error_disable = i_io_req.wdata[nsc_pkg::BIT_SYS_DIS];
            next_ctrl.speaker_gate = i_io_req.wdata[nsc_pkg::BIT_SPK_GATE];
            next_ctrl.counter2_gate = i_io_req.wdata[nsc_pkg::BIT_C2_GATE];
        end
        if (wr_index) begin
            next_global_nmi_mask = i_io_req.wdata[nsc_pkg::BIT_NMI_MASK];
            next_cmos_index = i_io_req.wdata[nsc_pkg::INDEX_W-1:0];
        end
        // Disabled source holds its flag clear; an event on the disabling
        // write cycle still lands, and is cleared one cycle later.
        next_system_error_flag = !ctrl.system_error_disable
                                 && (system_error_flag || system_error_seen);
        next_channel_check_flag = !ctrl.channel_check_disable
                                  && (channel_check_flag || channel_check_seen);
        next_refresh_toggle = refresh_toggle ^ i_refresh_done;
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl.channel_check_disable <= nsc_pkg::RST_CHK_DIS;
            ctrl.system_error_disable <= nsc_pkg::RST_SYS_DIS;
            ctrl.speaker_gate <= nsc_pkg::RST_SPK_GATE;
            ctrl.counter2_gate <= nsc_pkg::RST_C2_GATE;
            system_error_flag <= 1'h0;
            channel_check_flag <= 1'h0;
            refresh_toggle <= 1'h0;
            global_nmi_mask <= nsc_pkg::RST_NMI_MASK;
            cmos_index <= nsc_pkg::RST_INDEX;
        end else begin
            ctrl <= next_ctrl;
            system_error_flag <= next_system_error_flag;
            channel_check_flag <= next_channel_check_flag;
            refresh_toggle <= next_refresh_toggle;
            global_nmi_mask <= next_global_nmi_mask;
            cmos_index <= next_cmos_index;
        end
    end

    // ==========================================================
    // Read data and outputs
    function automatic logic [7:0] status_byte(input logic sys_flag,
                                               input logic chk_flag,
                                               input logic c2_level,
                                               input logic toggle,
                                               input nsc_pkg::nsc_ctrl_type c);
        logic [7:0] b;
        b = nsc_pkg::RST_BYTE;
        b[nsc_pkg::BIT_SYS_FLAG] = sys_flag;
        b[nsc_pkg::BIT_CHK_FLAG] = chk_flag;
        b[nsc_pkg::BIT_C2_LEVEL] = c2_level;
        b[nsc_pkg::BIT_REFRESH] = toggle;
        b[nsc_pkg::BIT_CHK_DIS] = c.channel_check_disable;
        b[nsc_pkg::BIT_SYS_DIS] = c.system_error_disable;
        b[nsc_pkg::BIT_SPK_GATE] = c.speaker_gate;
        b[nsc_pkg::BIT_C2_GATE] = c.counter2_gate;
        return b;
    endfunction

    logic [7:0] next_io_rdata;
    logic next_io_rdata_valid;
    nsc_pkg::nsc_isa_cycle_type next_isa_cycle;
    logic next_speaker_output;
    logic next_nmi;

    always_comb begin
        next_io_rdata = o_io_rdata;
        next_io_rdata_valid = rd_status || rd_index;
        if (rd_status) begin
            next_io_rdata = status_byte(system_error_flag, channel_check_flag,
                                        i_counter2_out, refresh_toggle, ctrl);
        end else if (rd_index) begin
            // Local copy answers; reserved bit 6 reads zero
            next_io_rdata = nsc_pkg::RST_BYTE;
            next_io_rdata[nsc_pkg::BIT_NMI_MASK] = global_nmi_mask;
            next_io_rdata[nsc_pkg::INDEX_W-1:0] = cmos_index;
        end
        // Index port cycles flow to the peripheral bus; only writes
        // address the clock chip, as it has always been write-only there.
        next_isa_cycle.rd = rd_index;
        next_isa_cycle.wr = wr_index;
        next_isa_cycle.clock_chip_select_low = !wr_index;
        next_isa_cycle.clock_chip_address_strobe = wr_index;
        next_isa_cycle.addr = (rd_index || wr_index) ? i_io_req.addr : o_isa_cycle.addr;
        next_isa_cycle.wdata = wr_index ? i_io_req.wdata : o_isa_cycle.wdata;
        next_speaker_output = ctrl.speaker_gate && i_counter2_out;
        next_nmi = !global_nmi_mask
                   && ((system_error_flag && !ctrl.system_error_disable)
                       || (channel_check_flag && !ctrl.channel_check_disable));
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_io_rdata <= nsc_pkg::RST_BYTE;
            o_io_rdata_valid <= 1'h0;
            o_isa_cycle.rd <= 1'h0;
            o_isa_cycle.wr <= 1'h0;
            o_isa_cycle.clock_chip_select_low <= 1'h1;
            o_isa_cycle.clock_chip_address_strobe <= 1'h0;
            o_isa_cycle.addr <= nsc_pkg::PORT_CMOS_INDEX;
            o_isa_cycle.wdata <= nsc_pkg::RST_BYTE;
            o_counter2_gate <= nsc_pkg::RST_C2_GATE;
            o_speaker_output <= 1'h0;
            o_nmi <= 1'h0;
            o_cmos_index <= nsc_pkg::RST_INDEX;
        end else begin
            o_io_rdata <= next_io_rdata;
            o_io_rdata_valid <= next_io_rdata_valid;
            o_isa_cycle <= next_isa_cycle;
            o_counter2_gate <= next_ctrl.counter2_gate;
            o_speaker_output <= next_speaker_output;
            o_nmi <= next_nmi;
            o_cmos_index <= next_cmos_index;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!rst_n);

    // A write in the same cycle takes the select, so only plain reads count
    sequence rd_index_req_s;
        rd_index && !wr_index;
    endsequence

    sequence isa_quiet_read_s;
        o_isa_cycle.rd && !o_isa_cycle.wr && o_isa_cycle.clock_chip_select_low
            && !o_isa_cycle.clock_chip_address_strobe;
    endsequence

    sequence wr_index_req_s;
        wr_index;
    endsequence

    sequence isa_strobed_write_s;
        o_isa_cycle.wr && !o_isa_cycle.clock_chip_select_low
            && o_isa_cycle.clock_chip_address_strobe;
    endsequence

    serr_latch_a: assert property (
        system_error_seen && !ctrl.system_error_disable |=> system_error_flag)
        else $error("system error flag not latched");

    serr_clear_a: assert property (
        ctrl.system_error_disable && $past(ctrl.system_error_disable) |-> !system_error_flag)
        else $error("system error flag set while disabled");

    chk_latch_a: assert property (
        channel_check_seen && !ctrl.channel_check_disable |=> channel_check_flag)
        else $error("channel check flag not latched");

    chk_clear_a: assert property (
        ctrl.channel_check_disable && $past(ctrl.channel_check_disable) |-> !channel_check_flag)
        else $error("channel check flag set while disabled");

    status_read_a: assert property (
        rd_status |=> o_io_rdata_valid
            && o_io_rdata[nsc_pkg::BIT_C2_LEVEL] == $past(i_counter2_out)
            && o_io_rdata[nsc_pkg::BIT_SYS_FLAG] == $past(system_error_flag))
        else $error("status read data wrong");

    refresh_flip_a: assert property (
        i_refresh_done |=> refresh_toggle != $past(refresh_toggle))
        else $error("refresh toggle did not flip");

    speaker_gate_a: assert property (
        !ctrl.speaker_gate ##1 !$past(wr_status) |-> !o_speaker_output)
        else $error("speaker driven while gated off");

    counter2_gate_a: assert property (
        wr_status |=> o_counter2_gate == $past(i_io_req.wdata[nsc_pkg::BIT_C2_GATE]))
        else $error("counter 2 gate not updated");

    nmi_mask_a: assert property (
        global_nmi_mask |=> !o_nmi)
        else $error("NMI delivered while masked");

    isa_read_a: assert property (
        rd_index_req_s |=> isa_quiet_read_s ##1 (!o_isa_cycle.rd || $past(rd_index)))
        else $error("index read not forwarded as quiet bus read");

    isa_write_a: assert property (
        wr_index_req_s |=> isa_strobed_write_s)
        else $error("index write not forwarded with strobe");

    index_write_a: assert property (
        wr_index |=> o_cmos_index == $past(i_io_req.wdata[5:0]))
        else $error("CMOS index not stored");

    nmi_raise_a: assert property (
        system_error_flag && !ctrl.system_error_disable && !global_nmi_mask |=> o_nmi)
        else $error("NMI not raised for pending source");
endmodule

// >>> src/nsc_pkg.sv
// Constants and carrier types for the NMI status and system control ports.
// Assumes a 16-bit I/O address space and byte-wide I/O data.
package nsc_pkg;

    // ==========================================================
    // Port addresses
    localparam int ADDR_W = 16;
    localparam logic [15:0] PORT_STATUS_CTRL = 16'h0061;
    localparam logic [15:0] PORT_CMOS_INDEX = 16'h0070;

    // ==========================================================
    // Status and control byte layout
    localparam int BIT_SYS_FLAG = 7;
    localparam int BIT_CHK_FLAG = 6;
    localparam int BIT_C2_LEVEL = 5;
    localparam int BIT_REFRESH = 4;
    localparam int BIT_CHK_DIS = 3;
    localparam int BIT_SYS_DIS = 2;
    localparam int BIT_SPK_GATE = 1;
    localparam int BIT_C2_GATE = 0;

    // ==========================================================
    // Index and mask byte layout
    localparam int BIT_NMI_MASK = 7;
    localparam int INDEX_W = 6;

    // ==========================================================
    // Reset values
    localparam logic RST_CHK_DIS = 1'h1;
    localparam logic RST_SYS_DIS = 1'h1;
    localparam logic RST_SPK_GATE = 1'h0;
    localparam logic RST_C2_GATE = 1'h0;
    localparam logic RST_NMI_MASK = 1'h1;
    localparam logic [5:0] RST_INDEX = 6'h00;
    localparam logic [7:0] RST_BYTE = 8'h00;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } nsc_io_req_type;

    typedef struct packed {
        logic rd;
        logic wr;
        logic clock_chip_select_low;
        logic clock_chip_address_strobe;
        logic [15:0] addr;
        logic [7:0] wdata;
    } nsc_isa_cycle_type;

    typedef struct packed {
        logic channel_check_disable;
        logic system_error_disable;
        logic speaker_gate;
        logic counter2_gate;
    } nsc_ctrl_type;

endpackage

// >>> src/nsc_pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes pins are asynchronous to i_mclk; reset is the synchronised copy.
`timescale 1ns/1ps
module nsc_pin_sync #(
    parameter int WIDTH = 2,
    parameter logic [WIDTH-1:0] IDLE = '1
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_pin,
    output logic [WIDTH-1:0] o_level
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_level;

    // ==========================================================
    // Filter: a change counts only when stages two and three agree
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : o_level[i];
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta <= IDLE;
            stage2 <= IDLE;
            stage3 <= IDLE;
            o_level <= IDLE;
        end else begin
            meta <= i_pin;
            stage2 <= meta;
            stage3 <= stage2;
            o_level <= next_level;
        end
    end
endmodule

// >>> sim/nsc_board_model.sv
// Board-side model: error pins, counter 2 output and refresh pulses.
// Assumes the bench calls its tasks; every change lands on a falling edge.
`timescale 1ns/1ps
module nsc_board_model (
    input wire logic i_mclk,
    output logic o_system_error_low,
    output logic o_channel_check_low,
    output logic o_counter2_out,
    output logic o_refresh_done
);
    // ==========================================================
    // Idle levels
    // Error pins are pulled up, so a released pin reads high
    initial begin
        o_system_error_low = 1'h1;
        o_channel_check_low = 1'h1;
        o_counter2_out = 1'h0;
        o_refresh_done = 1'h0;
    end

    // ==========================================================
    // Board events
    // Pulse is held long enough to pass the agreement filter
    task automatic pulse_system_error(input int n);
        @(negedge i_mclk);
        o_system_error_low = !o_system_error_low;
        repeat (n) @(negedge i_mclk);
        o_system_error_low = !o_system_error_low;
    endtask

    task automatic set_channel_check_low(input logic v);
        @(negedge i_mclk);
        o_channel_check_low = v;
    endtask

    task automatic set_counter2(input logic v);
        @(negedge i_mclk);
        o_counter2_out = v;
    endtask

    task automatic refresh_once;
        @(negedge i_mclk);
        o_refresh_done = !o_refresh_done;
        @(negedge i_mclk);
        o_refresh_done = !o_refresh_done;
    endtask
endmodule

// >>> sim/testbench.sv
// Self-checking bench for the NMI status and control ports.
// Assumes the board model supplies pins; I/O cycles are driven here.
`timescale 1ns/1ps
module testbench;
    logic i_mclk;
    logic i_arst_n;
    nsc_pkg::nsc_io_req_type req;
    logic serr_n, chk_n, c2, rfsh, valid, c2_gate, spk, nmi, ok;
    logic [7:0] rdata;
    logic [7:0] got;
    logic [5:0] idx;
    logic [7:0] last_wdata = 8'h00;
    nsc_pkg::nsc_isa_cycle_type isa;
    int fail_count = 0;
    int n_compared = 0;
    int isa_rd = 0;
    int isa_wr = 0;

    nsc_nmi_ctrl i_dut (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_io_req(req),
        .i_system_error_low(serr_n), .i_channel_check_low(chk_n), .i_counter2_out(c2),
        .i_refresh_done(rfsh), .o_io_rdata(rdata), .o_io_rdata_valid(valid),
        .o_isa_cycle(isa), .o_counter2_gate(c2_gate), .o_speaker_output(spk),
        .o_nmi(nmi), .o_cmos_index(idx));
    nsc_board_model i_board (.i_mclk(i_mclk), .o_system_error_low(serr_n),
        .o_channel_check_low(chk_n), .o_counter2_out(c2), .o_refresh_done(rfsh));

    // ==========================================================
    // Clock
    initial begin
        i_mclk = 1'h0;
        forever #2.5 i_mclk = ~i_mclk;
    end

    // ==========================================================
    // Access tasks
    task automatic check(input logic [7:0] act, input logic [7:0] exp, input string what);
        n_compared++;
        if (act !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, act, exp);
        end
    endtask

    task automatic io_write(input logic [15:0] a, input logic [7:0] d);
        @(negedge i_mclk);
        req.wr = 1'h1;
        req.addr = a;
        req.wdata = d;
        last_wdata = d;
        @(negedge i_mclk);
        req.wr = 1'h0;
    endtask

    // Answer is polled over a few edges so a late valid is caught, not hung on
    task automatic io_read(input logic [15:0] a, output logic [7:0] d, output logic k_ok);
        @(negedge i_mclk);
        req.rd = 1'h1;
        req.addr = a;
        @(negedge i_mclk);
        req.rd = 1'h0;
        k_ok = 1'h0;
        d = 8'h00;
        for (int k = 0; k < 3 && !k_ok; k++) begin
            if (valid === 1'h1) begin
                k_ok = 1'h1;
                d = rdata;
            end else begin
                @(negedge i_mclk);
            end
        end
    endtask

    task automatic read_check(input logic [15:0] a, input logic [7:0] exp, input string what);
        io_read(a, got, ok);
        check({7'h00, ok}, 8'h01, "read answered");
        check(got, exp, what);
    endtask

    task automatic bit_check(input logic b, input logic exp, input string what);
        check({7'h00, b}, {7'h00, exp}, what);
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // Peripheral bus monitor
    always @(negedge i_mclk) begin
        if (isa.rd === 1'h1) begin
            isa_rd++;
            check({6'h00, isa.clock_chip_select_low, isa.clock_chip_address_strobe}, 8'h02,
                "read select and strobe");
        end
        if (isa.wr === 1'h1) begin
            isa_wr++;
            check({6'h00, isa.clock_chip_select_low, isa.clock_chip_address_strobe}, 8'h01,
                "write select and strobe");
            check(isa.addr[7:0], 8'h70, "bus address");
            check(isa.wdata, last_wdata, "bus write data");
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        i_arst_n = 1'h0;
        req = '0;
        repeat (16) @(negedge i_mclk);
        i_arst_n = 1'h1;
        repeat (4) @(negedge i_mclk);
        read_check(16'h0061, 8'h0C, "status after reset");
        read_check(16'h0070, 8'h80, "index after reset");
        bit_check(nmi, 1'h0, "nmi after reset");
        // Read-only status bits are always written as zero
        io_write(16'h0061, 8'h0F);
        repeat (1) @(negedge i_mclk);
        bit_check(c2_gate, 1'h1, "counter gate on");
        read_check(16'h0061, 8'h0F, "control bits written");
        i_board.set_counter2(1'h1);
        repeat (2) @(negedge i_mclk);
        bit_check(spk, 1'h1, "speaker follows counter");
        read_check(16'h0061, 8'h2F, "counter level");
        io_write(16'h0061, 8'h0D);
        repeat (2) @(negedge i_mclk);
        bit_check(spk, 1'h0, "speaker gated off");
        io_write(16'h0061, 8'h0C);
        repeat (1) @(negedge i_mclk);
        bit_check(c2_gate, 1'h0, "counter gate off");
        i_board.set_counter2(1'h0);
        i_board.refresh_once();
        read_check(16'h0061, 8'h1C, "refresh toggle set");
        i_board.refresh_once();
        read_check(16'h0061, 8'h0C, "refresh toggle back");
        i_board.pulse_system_error(8);
        repeat (10) @(negedge i_mclk);
        read_check(16'h0061, 8'h0C, "disabled source");
        io_write(16'h0061, 8'h08);
        i_board.pulse_system_error(8);
        repeat (10) @(negedge i_mclk);
        read_check(16'h0061, 8'h88, "system error latched");
        bit_check(nmi, 1'h0, "masked nmi");
        io_write(16'h0070, 8'h05);
        repeat (3) @(negedge i_mclk);
        bit_check(nmi, 1'h1, "nmi unmasked");
        check({2'h0, idx}, 8'h05, "cmos index");
        check(isa_wr[7:0], 8'h01, "bus write count");
        read_check(16'h0070, 8'h05, "index readback");
        // Monitor counts on this same edge; let it run first
        @(negedge i_mclk);
        check(isa_rd[7:0], 8'h02, "bus read count");
        io_write(16'h0070, 8'hC5);
        repeat (3) @(negedge i_mclk);
        bit_check(nmi, 1'h0, "mask blocks nmi");
        read_check(16'h0070, 8'h85, "reserved bit reads zero");
        io_write(16'h0070, 8'h05);
        repeat (3) @(negedge i_mclk);
        bit_check(nmi, 1'h1, "nmi again");
        io_write(16'h0061, 8'h0C);
        repeat (3) @(negedge i_mclk);
        bit_check(nmi, 1'h0, "nmi cleared");
        read_check(16'h0061, 8'h0C, "system flag cleared");
        io_write(16'h0061, 8'h04);
        i_board.set_channel_check_low(1'h0);
        repeat (10) @(negedge i_mclk);
        read_check(16'h0061, 8'h44, "channel check latched");
        bit_check(nmi, 1'h1, "channel nmi");
        // Pin still low: a disabled source must stay clear
        io_write(16'h0061, 8'h0C);
        repeat (3) @(negedge i_mclk);
        read_check(16'h0061, 8'h0C, "channel flag held off");
        bit_check(nmi, 1'h0, "channel nmi gone");
        i_board.set_channel_check_low(1'h1);
        // Reset in mid-run must bring toggle, index and mask back
        i_board.refresh_once();
        @(negedge i_mclk);
        i_arst_n = 1'h0;
        repeat (2) @(negedge i_mclk);
        i_arst_n = 1'h1;
        repeat (4) @(negedge i_mclk);
        check({2'h0, idx}, 8'h00, "index after second reset");
        read_check(16'h0061, 8'h0C, "status after second reset");
        read_check(16'h0070, 8'h80, "mask after second reset");
        io_read(16'h0161, got, ok);
        check({7'h00, ok}, 8'h00, "unmapped port silent");
        end_of_test();
    end
endmodule
